// ### sent_frame_transmitter.sv
// SENT frame transmitter with APB registers and sample buffer
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module sent_frame_transmitter
    import sent_pkg::*;
(
    input  wire logic              pclk,                       // APB clock, 25 MHz
    input  wire logic              presetn,                    // Async reset, active low
    input  wire logic              psel,                       // APB select
    input  wire logic              penable,                    // APB access phase
    input  wire logic              pwrite,                     // APB write
    input  wire logic [7:0]        paddr,                      // APB byte address
    input  wire logic [31:0]       pwdata,                     // APB write data
    output logic [31:0]            prdata,                     // APB read data
    output logic                   pready,                     // APB ready
    output logic                   pslverr,                    // APB error
    input  wire logic              comm_mode,                  // Programming mode active
    output logic                   sent_out_o,                 // Line output value
    output logic                   sent_out_oe,                // Line pulled low when high
    output logic [SLEW_W-1:0]      falling_edge_slew_setting   // Driver slew select
);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    stream_if #(.WIDTH(FIFO_WIDTH)) push_s ();
    stream_if #(.WIDTH(FIFO_WIDTH)) pop_s ();

    logic [31:0]       ctrl_reg;
    logic [TICK_W-1:0] tick_reg;
    logic [31:0]       prdata_reg;
    logic [31:0]       rdata_next;
    logic [31:0]       status_word;
    logic [15:0]       frames_reg;
    logic [15:0]       sample_reg;
    state_t            state_reg;
    logic [2:0]        idx_reg;
    logic [5:0]        tcnt_reg;
    logic [5:0]        seg_len;
    logic [5:0]        low_cnt_reg;
    logic [3:0]        nib_val;
    logic [1:0]        ser_bits;
    logic [11:0]       angle_w;
    logic [LVL_W-1:0]  level;
    logic              line_low_reg;
    logic              tick;
    logic              run;
    logic              pause_en;
    logic              seg_end;
    logic              to_sync;
    logic              frame_start;
    logic              drive_low;
    logic              acc_phase;
    logic              wr_en;

    // Address decode shared by error answer and write gating
    function automatic logic addr_mapped(input logic [7:0] a);
        if (a == CTRL_OFFSET) begin
            return 1'b1;
        end else if (a == TICK_OFFSET) begin
            return 1'b1;
        end else if (a == SAMPLE_OFFSET) begin
            return 1'b1;
        end else if (a == STATUS_OFFSET) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : addr_mapped

    sent_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .in_s    (push_s),
        .out_s   (pop_s),
        .level   (level)
    );

    sent_tick_div u_tick (
        .pclk         (pclk),
        .presetn      (presetn),
        .run          (run),
        .tick_setting (tick_reg),
        .tick         (tick)
    );

    // APB handshake; a sample write stalls while the buffer is full
    assign acc_phase    = psel && penable;
    assign push_s.valid = acc_phase && pwrite && (paddr == SAMPLE_OFFSET);
    assign push_s.data  = pwdata[FIFO_WIDTH-1:0];
    assign pready       = push_s.valid ? push_s.ready : 1'b1;
    assign pslverr      = acc_phase && !addr_mapped(paddr);
    assign wr_en        = acc_phase && pwrite && pready && addr_mapped(paddr);
    assign prdata       = prdata_reg;

    // Status word assembly
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[LEVEL_LSB +: LVL_W] = level;
        status_word[BUSY_BIT] = (state_reg != ST_IDLE);
        status_word[FRAMES_LSB +: 16] = frames_reg;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (paddr == CTRL_OFFSET) begin
            rdata_next = ctrl_reg;
        end else if (paddr == TICK_OFFSET) begin
            rdata_next = {{(32 - TICK_W){1'b0}}, tick_reg};
        end else if (paddr == SAMPLE_OFFSET) begin
            rdata_next = {16'h0000, sample_reg};
        end else if (paddr == STATUS_OFFSET) begin
            rdata_next = status_word;
        end
    end

    // Read data captured in the setup phase, so reads never wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rdata_next;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && (paddr == CTRL_OFFSET)) begin
            ctrl_reg <= pwdata & CTRL_MASK;
        end
    end

    // Tick setting, clamped into the legal span
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= TICK_RESET;
        end else if (wr_en && (paddr == TICK_OFFSET)) begin
            if (pwdata < 32'(TICK_MIN)) begin
                tick_reg <= TICK_MIN;
            end else if (pwdata > 32'(TICK_MAX)) begin
                tick_reg <= TICK_MAX;
            end else begin
                tick_reg <= pwdata[TICK_W-1:0];
            end
        end
    end

    assign falling_edge_slew_setting = ctrl_reg[SLEW_LSB +: SLEW_W];
    assign run      = (ctrl_reg[MODE_LSB +: MODE_W] != 2'b00) && !comm_mode;
    assign pause_en = ctrl_reg[PAUSE_BIT];
    assign angle_w  = sample_reg[ANGLE_LSB +: ANGLE_W];
    assign ser_bits = (ctrl_reg[SERCFG_LSB +: 2] != 2'b00) ? ctrl_reg[SERBITS_LSB +: 2] : 2'b00;

    // Value of the nibble now on the line
    always_comb begin
        nib_val = 4'h0;
        case (idx_reg)
            IDX_STATUS: nib_val = {sample_reg[DEVSTAT_LSB +: 2], ser_bits};
            IDX_DATA0:  nib_val = angle_w[11:8];
            IDX_DATA1:  nib_val = angle_w[7:4];
            IDX_DATA2:  nib_val = angle_w[3:0];
            IDX_CRC:    nib_val = frame_crc(angle_w);
            default:    nib_val = 4'h0;
        endcase
    end

    // Segment length in ticks: sync, value nibble or pause
    always_comb begin
        seg_len = SYNC_TICKS;
        case (state_reg)
            ST_NIB:   seg_len = LOW_TICKS + HIGH_BASE_TICKS + {2'b00, nib_val};
            ST_PAUSE: seg_len = PAUSE_TICKS;
            default:  seg_len = SYNC_TICKS;
        endcase
    end

    // Segment end and frame start; a new sample is drawn only at a sync
    assign seg_end     = tick && (state_reg != ST_IDLE) && (tcnt_reg == seg_len - 6'h01);
    assign to_sync     = (state_reg == ST_PAUSE) || ((state_reg == ST_NIB) && (idx_reg == IDX_CRC) && !pause_en);
    assign frame_start = run && ((tick && (state_reg == ST_IDLE)) || (seg_end && to_sync));
    assign pop_s.ready = frame_start;
    assign drive_low   = (state_reg != ST_IDLE) && (tcnt_reg < LOW_TICKS);

    // Frame sequencer; leaving run drops the frame in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            idx_reg   <= 3'h0;
            tcnt_reg  <= 6'h00;
        end else if (!run) begin
            state_reg <= ST_IDLE;
            idx_reg   <= 3'h0;
            tcnt_reg  <= 6'h00;
        end else if (frame_start) begin
            state_reg <= ST_SYNC;
            idx_reg   <= 3'h0;
            tcnt_reg  <= 6'h00;
        end else if (seg_end) begin
            tcnt_reg <= 6'h00;
            if (state_reg == ST_SYNC) begin
                state_reg <= ST_NIB;
                idx_reg   <= IDX_STATUS;
            end else if (idx_reg != IDX_CRC) begin
                idx_reg <= idx_reg + 3'h1;
            end else begin
                state_reg <= ST_PAUSE;
                idx_reg   <= 3'h0;
            end
        end else if (tick && (state_reg != ST_IDLE)) begin
            tcnt_reg <= tcnt_reg + 6'h01;
        end
    end

    // Sample latch; an empty buffer repeats the last sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= 16'h0000;
        end else if (frame_start && pop_s.valid) begin
            sample_reg <= pop_s.data;
        end
    end

    // Completed frame counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_reg <= 16'h0000;
        end else if (seg_end && (state_reg == ST_NIB) && (idx_reg == IDX_CRC)) begin
            frames_reg <= frames_reg + 16'h0001;
        end
    end

    // Line driver; open drain, so only the low level is driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_low_reg <= 1'b0;
        end else begin
            line_low_reg <= drive_low && run;
        end
    end

    assign sent_out_o  = 1'b0;
    assign sent_out_oe = line_low_reg;

    // Helper: ticks spent in the current low interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_reg <= 6'h00;
        end else if (!drive_low) begin
            low_cnt_reg <= 6'h00;
        end else if (tick) begin
            low_cnt_reg <= low_cnt_reg + 6'h01;
        end
    end

    property p_low_five;
        @(posedge pclk) disable iff (!presetn || !run)
        $fell(drive_low) && (state_reg != ST_IDLE) |-> low_cnt_reg == LOW_TICKS;
    endproperty
    a_low_five: assert property (p_low_five) else $error("Low interval not five ticks");

    property p_nib_len;
        @(posedge pclk) disable iff (!presetn || !run)
        seg_end && (state_reg == ST_NIB) |-> (tcnt_reg >= 6'h0B) && (tcnt_reg <= 6'h1A);
    endproperty
    a_nib_len: assert property (p_nib_len) else $error("Nibble outside 12 to 27 ticks");

    property p_sync_len;
        @(posedge pclk) disable iff (!presetn || !run)
        seg_end && (state_reg == ST_SYNC) |-> tcnt_reg == 6'h37;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("Sync pulse not 56 ticks");

    property p_sync_then_status;
        @(posedge pclk) disable iff (!presetn || !run)
        seg_end && (state_reg == ST_SYNC) |=> (state_reg == ST_NIB) && (idx_reg == IDX_STATUS);
    endproperty
    a_sync_then_status: assert property (p_sync_then_status) else $error("Status nibble did not follow sync");

    property p_crc_then_next;
        @(posedge pclk) disable iff (!presetn || !run)
        seg_end && (state_reg == ST_NIB) && (idx_reg == IDX_CRC) |=>
            (pause_en ? (state_reg == ST_PAUSE) : (state_reg == ST_SYNC));
    endproperty
    a_crc_then_next: assert property (p_crc_then_next) else $error("Wrong segment after CRC");

    property p_crc_value;
        @(posedge pclk) disable iff (!presetn || !run)
        (state_reg == ST_NIB) && (idx_reg == IDX_CRC) && (angle_w == 12'h000) |-> nib_val == 4'h9;
    endproperty
    a_crc_value: assert property (p_crc_value) else $error("CRC of zero angle wrong");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_reg[MODE_LSB +: MODE_W] == 2'b00) |=> !sent_out_oe && (state_reg == ST_IDLE);
    endproperty
    a_off: assert property (p_off) else $error("Line driven while output is off");

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        comm_mode |=> (state_reg == ST_IDLE) && !sent_out_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("Frame continued in programming mode");

    property p_serial_off;
        @(posedge pclk) disable iff (!presetn || !run)
        (idx_reg == IDX_STATUS) && (ctrl_reg[SERCFG_LSB +: 2] == 2'b00) |-> nib_val[1:0] == 2'b00;
    endproperty
    a_serial_off: assert property (p_serial_off) else $error("Serial bits sent while disabled");

    property p_slew;
        @(posedge pclk) disable iff (!presetn)
        wr_en && (paddr == CTRL_OFFSET) |=> falling_edge_slew_setting == $past(pwdata[SLEW_LSB +: SLEW_W]);
    endproperty
    a_slew: assert property (p_slew) else $error("Slew setting not taken from write");

    c_frame_pause: cover property (@(posedge pclk) disable iff (!presetn)
        seg_end && (state_reg == ST_PAUSE));
    c_buffer_stall: cover property (@(posedge pclk) disable iff (!presetn)
        push_s.valid && !push_s.ready);
    c_abort_mid: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(comm_mode) && (state_reg == ST_NIB));
endmodule : sent_frame_transmitter

// ### sent_pkg.sv
// Constants, types and CRC helpers for the SENT frame transmitter
// Overview of operation
// - Each nibble is a low interval then a high interval; low marks the boundary.
// - The low interval of every nibble lasts exactly five ticks.
// - The high interval length carries the four-bit value of the nibble.
// - The tick period comes from a programmable tick-time setting.
// - Nibble length equals low ticks plus high ticks.
// - Frame order: sync, status, data nibbles, CRC, optional pause.
// - Status nibble holds device status plus serial bits chosen by a serial setting.
// - Value v gives v plus 7 high ticks, totals 12 to 27 ticks.
// - The data nibbles after the status nibble carry the angle.
// - A CRC nibble follows the data nibbles.
// - A protocol selection of zero turns the SENT output off.
// - A driver setting adjusts the slew of the falling edge.
// - The angle is a 12-bit unsigned value, 0 to 4095, in the data nibbles.
// - The tick time is programmable from 0.5 us to 7.9 us.
// - Entering programming mode stops frames at once, dropping any frame under way.
package sent_pkg;
    // Register byte offsets
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  TICK_OFFSET     = 8'h04;
    localparam logic [7:0]  SAMPLE_OFFSET   = 8'h08;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h0C;
    // Control fields
    localparam int          MODE_LSB        = 0;
    localparam int          MODE_W          = 2;
    localparam int          PAUSE_BIT       = 2;
    localparam int          SERCFG_LSB      = 4;
    localparam int          SERBITS_LSB     = 6;
    localparam int          SLEW_LSB        = 8;
    localparam int          SLEW_W          = 3;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_07F7;
    // Tick setting, in units of 100 ns
    localparam int          TICK_W          = 7;
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          TICK_UNIT_NS    = 100;
    localparam int          TICK_MIN_NS     = 500;
    localparam int          TICK_MAX_NS     = 7900;
    localparam logic [6:0]  TICK_MIN        = 7'(TICK_MIN_NS / TICK_UNIT_NS);
    localparam logic [6:0]  TICK_MAX        = 7'(TICK_MAX_NS / TICK_UNIT_NS);
    localparam logic [6:0]  TICK_RESET      = 7'h1E;
    // Sample word and status word fields
    localparam int          ANGLE_LSB       = 0;
    localparam int          ANGLE_W         = 12;
    localparam int          DEVSTAT_LSB     = 12;
    localparam int          LEVEL_LSB       = 0;
    localparam int          BUSY_BIT        = 8;
    localparam int          FRAMES_LSB      = 16;
    // Frame timing in ticks
    localparam logic [5:0]  LOW_TICKS       = 6'h05;
    localparam logic [5:0]  HIGH_BASE_TICKS = 6'h07;
    localparam logic [5:0]  SYNC_TICKS      = 6'h38;
    localparam logic [5:0]  PAUSE_TICKS     = 6'h14;
    // Nibble positions within a frame
    localparam logic [2:0]  IDX_STATUS      = 3'h1;
    localparam logic [2:0]  IDX_DATA0       = 3'h2;
    localparam logic [2:0]  IDX_DATA1       = 3'h3;
    localparam logic [2:0]  IDX_DATA2       = 3'h4;
    localparam logic [2:0]  IDX_CRC         = 3'h5;
    localparam logic [3:0]  CRC_SEED        = 4'h5;
    // Sample buffer shape
    localparam int          FIFO_WIDTH      = 16;
    localparam int          FIFO_DEPTH      = 16;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SYNC  = 2'b01,
        ST_NIB   = 2'b10,
        ST_PAUSE = 2'b11
    } state_t;

    // One step of the x^4+x^3+x^2+1 CRC, table driven
    function automatic logic [3:0] crc4_step(input logic [3:0] crc, input logic [3:0] nib);
        logic [3:0] t;
        t = 4'h0;
        case (crc)
            4'h0: t = 4'h0;  4'h1: t = 4'hD;  4'h2: t = 4'h7;  4'h3: t = 4'hA;
            4'h4: t = 4'hE;  4'h5: t = 4'h3;  4'h6: t = 4'h9;  4'h7: t = 4'h4;
            4'h8: t = 4'h1;  4'h9: t = 4'hC;  4'hA: t = 4'h6;  4'hB: t = 4'hB;
            4'hC: t = 4'hF;  4'hD: t = 4'h2;  4'hE: t = 4'h8;  default: t = 4'h5;
        endcase
        return t ^ nib;
    endfunction : crc4_step

    // CRC over the three angle nibbles, closed with a zero nibble
    function automatic logic [3:0] frame_crc(input logic [11:0] angle);
        logic [3:0] c;
        c = crc4_step(CRC_SEED, angle[11:8]);
        c = crc4_step(c, angle[7:4]);
        c = crc4_step(c, angle[3:0]);
        return crc4_step(c, 4'h0);
    endfunction : frame_crc
endpackage : sent_pkg

// ### stream_if.sv
// Valid/ready stream carrier between the transmitter and its sample buffer
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 16);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### sent_fifo.sv
// Synchronous sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sent_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                   pclk,     // Clock
    input  wire logic                   presetn,  // Async reset, active low
    stream_if.snk                       in_s,     // Filling side
    stream_if.src                       out_s,    // Draining side
    output logic [$clog2(DEPTH):0]      level     // Words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Full refuses pushes, so back-pressure reaches the bus
    assign in_s.ready  = (count_reg != (AW + 1)'(DEPTH));
    assign out_s.valid = (count_reg != '0);
    assign out_s.data  = mem[rd_ptr_reg];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;
    assign level       = count_reg;

    // Storage has no reset; only the pointers define content
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_s.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    property p_no_overflow;
        @(posedge pclk) disable iff (!presetn)
        (count_reg == (AW + 1)'(DEPTH)) && !pop |=> count_reg == (AW + 1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("FIFO count moved while full");
endmodule : sent_fifo

// ### sent_tick_div.sv
// Tick enable generator; fractional accumulator gives exact mean tick
`timescale 1ns/1ps
module sent_tick_div
    import sent_pkg::*;
(
    input  wire logic              pclk,          // Clock
    input  wire logic              presetn,       // Async reset, active low
    input  wire logic              run,           // Generator enabled
    input  wire logic [TICK_W-1:0] tick_setting,  // Tick time in 100 ns units
    output logic                   tick           // One-cycle tick pulse
);
    logic [15:0] acc_reg;
    logic [15:0] acc_next;
    logic [15:0] period_ns;

    // Tick period may not be whole cycles, so jitter is one cycle at most
    assign period_ns = 16'(tick_setting) * 16'(TICK_UNIT_NS);
    assign acc_next  = acc_reg + 16'(CLK_PERIOD_NS);

    // Accumulate elapsed time and emit a pulse each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 16'h0000;
            tick    <= 1'b0;
        end else if (!run) begin
            acc_reg <= 16'h0000;
            tick    <= 1'b0;
        end else if (acc_next >= period_ns) begin
            acc_reg <= acc_next - period_ns;
            tick    <= 1'b1;
        end else begin
            acc_reg <= acc_next;
            tick    <= 1'b0;
        end
    end

    property p_tick_spacing;
        @(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("Ticks closer than the shortest tick");
endmodule : sent_tick_div

// ### sent_rx_model.sv
// Receiver model: pulled-up line, pulse lengths in ticks
`timescale 1ns/1ps
module sent_rx_model (
    input  wire logic        pclk,      // Clock
    input  wire logic        line_oe,   // Device pulls line
    input  wire logic        line_o,    // Driven value
    input  wire logic [15:0] tick_ns,   // Nominal tick
    output logic [7:0]       ticks,     // Fall to fall
    output logic [7:0]       low_ticks, // Low part
    output logic             stb        // One per pulse
);
    logic line;
    logic line_d = 1'b1;
    logic armed = 1'b0;
    int   cyc = 0;
    int   low = 0;
    // Pull-up holds the line high when released
    assign line = line_oe ? line_o : 1'b1;
    // Rounding absorbs the one-cycle jitter of the tick divider
    always @(posedge pclk) begin
        line_d <= line;
        stb <= 1'b0;
        cyc <= cyc + 1;
        low <= low + int'(!line);
        if (line_d && !line) begin
            ticks <= 8'((cyc * 40 + tick_ns / 2) / tick_ns);
            low_ticks <= 8'((low * 40 + tick_ns / 2) / tick_ns);
            stb <= armed;
            armed <= 1'b1;
            cyc <= 1;
            low <= 1;
        end
    end
endmodule : sent_rx_model

// ### sent_frame_transmitter_tb.sv
// Bench: APB driver, frame model, scoreboard
`timescale 1ns/1ps
module sent_frame_transmitter_tb;
    import sent_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, comm_mode = 1;
    logic pready, pslverr, oe, o, stb, e, cmp_on = 1, bad = 0;
    logic [7:0]  paddr = 0, ticks, low_t;
    logic [31:0] pwdata = 0, prdata, q, cw, rs = 32'h9610;
    logic [2:0]  slew;
    logic [13:0] s;
    int n_mismatch = 0, tests_run = 0;
    int exq[$];
    sent_frame_transmitter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comm_mode(comm_mode), .sent_out_o(o), .sent_out_oe(oe), .falling_edge_slew_setting(slew));
    sent_rx_model rx_u (.pclk(pclk), .line_oe(oe), .line_o(o), .tick_ns(16'h01F4), .ticks(ticks),
        .low_ticks(low_t), .stb(stb));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd
    // Bitwise form of the four-bit CRC step, independent of the design table
    function automatic logic [3:0] crc(input logic [3:0] c, input logic [3:0] n);
        logic [4:0] x;
        x = {1'b0, c};
        repeat (4) x = {x[3:0], 1'b0} ^ (x[3] ? 5'h1D : 5'h00);
        return x[3:0] ^ n;
    endfunction : crc
    // Expected pulse list of one frame, pause enabled
    task automatic model(input logic [13:0] v, input logic [7:0] c);
        int k;
        k = crc(crc(crc(crc(4'h5, v[11:8]), v[7:4]), v[3:0]), 4'h0);
        exq = {exq, 56, 12 + {v[13:12], (c[5:4] != 2'b00) ? c[7:6] : 2'b00}, 12 + v[11:8], 12 + v[7:4],
            12 + v[3:0], 12 + k, 20};
    endtask : model
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // One APB transfer; request held until the edge that sees pready high, answer taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial forever #20 pclk = ~pclk;
    initial begin
        repeat (95000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end
    // Received pulses are checked against the model while cmp_on is set and the expected queue is not empty
    always @(posedge pclk) if (stb && cmp_on && exq.size() > 0) begin
        check(low_t, 5);
        check(ticks, exq.pop_front());
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, CTRL_OFFSET, 0);
        check(q, CTRL_RESET);
        apb(0, 8'h10, 0);
        check(q, 0);
        check(e, 1);
        apb(1, TICK_OFFSET, 127);
        apb(0, TICK_OFFSET, 0);
        check(q, TICK_MAX);
        apb(1, TICK_OFFSET, 3);
        apb(0, TICK_OFFSET, 0);
        check(q, TICK_MIN);
        cw = rnd() & 32'h0000_07F0 | 32'h0000_0005;
        apb(1, CTRL_OFFSET, cw);
        check(slew, cw[10:8]);
        $display("registers done");
        repeat (17) begin
            s = (exq.size() == 0) ? 14'h0000 : 14'(rnd());
            model(s, cw[7:0]);
            if (exq.size() <= 112) apb(1, SAMPLE_OFFSET, s);
        end
        apb(0, STATUS_OFFSET, 0);
        check(q[4:0], 16);
        fork
            apb(1, SAMPLE_OFFSET, s);
            begin
                repeat (20) @(posedge pclk);
                check(pready, 0);
                comm_mode <= 0;
            end
        join
        while (exq.size() > 0) @(posedge pclk);
        cmp_on <= 0;
        apb(0, SAMPLE_OFFSET, 0);
        check(q, 32'(s));
        $display("frames done");
        while (oe !== 1) @(posedge pclk);
        comm_mode <= 1;
        repeat (2) @(posedge pclk);
        check(oe, 0);
        apb(1, CTRL_OFFSET, 0);
        comm_mode <= 0;
        repeat (400) @(posedge pclk) bad |= oe;
        check(bad, 0);
        $display("abort and off done");
        wrap_up();
    end
endmodule : sent_frame_transmitter_tb
